// File: common/txq_pkg.sv
// Purpose: shared constants and types of the transmit queue block
// Assumes: registers are 16 bits, byte addressed on the serial link
// Notes: queue memory is a byte-wide ring of the full transmit space
package txq_pkg;
    // queue geometry
    localparam int TXQ_DEPTH = 6144;
    localparam logic [12:0] TXQ_SIZE = 13'(TXQ_DEPTH);
    localparam logic [12:0] HDR_BYTES = 13'h0004;
    localparam logic [10:0] FRAME_MAX = 11'h7d0;
    // register byte offsets
    localparam logic [7:0] OFS_TXC = 8'h70;
    localparam logic [7:0] OFS_TXFREE = 8'h78;
    localparam logic [7:0] OFS_TXQC = 8'h80;
    localparam logic [7:0] OFS_RXQC = 8'h82;
    localparam logic [7:0] OFS_TXDP = 8'h84;
    localparam logic [7:0] OFS_IER = 8'h90;
    localparam logic [7:0] OFS_ISR = 8'h92;
    localparam logic [7:0] OFS_SPACE = 8'h9e;
    // field positions
    localparam int TXC_EN = 0;
    localparam int TXC_CRC = 1;
    localparam int TXC_PAD = 2;
    localparam int TXC_FLOW = 3;
    localparam int TXC_CSUM = 5;
    localparam int TQ_MANUAL = 0;
    localparam int TQ_SPACE = 1;
    localparam int TQ_AUTO = 2;
    localparam int RQ_DMA = 3;
    localparam int DP_AUTOINC = 14;
    localparam int IRQ_TXDONE = 14;
    localparam int IRQ_SPACE = 6;
    localparam int CW_INTR = 15;
    typedef enum logic [1:0] {
        OP_REG_RD = 2'b00, OP_REG_WR = 2'b01, OP_RXQ_RD = 2'b10, OP_TXQ_WR = 2'b11
    } op_e;
    typedef enum logic [3:0] {
        R_NONE = 4'b0000, R_TXC = 4'b0001, R_FREE = 4'b0010, R_TXQC = 4'b0011,
        R_RXQC = 4'b0100, R_TXDP = 4'b0101, R_IER = 4'b0110, R_ISR = 4'b0111,
        R_SPACE = 4'b1000
    } reg_e;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_ADDR = 3'b001, TX_LOAD = 3'b010, TX_SEND = 3'b011,
        TX_DONE = 3'b100
    } tx_e;
endpackage

// File: common/spi_link_if.sv
// Purpose: carries nibble events and bytes between the link and core clocks
// Assumes: held and out_byte stay stable for a nibble time around each event
// Notes: evt_toggle flips once per four serial bits
`timescale 1ns/10ps
interface spi_link_if;
    logic evt_toggle;
    logic [7:0] held;
    logic [7:0] out_byte;
    modport link (output evt_toggle, output held, input out_byte);
    modport core (input evt_toggle, input held, output out_byte);
endinterface

// File: design/txq_mem.sv
// Purpose: byte-wide transmit packet memory
// Assumes: one write and one read port on the core clock
// Notes: read data come out of a register, one cycle after the address
`timescale 1ns/10ps
module txq_mem
    import txq_pkg::*;
(
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [12:0] wa,
    input wire logic [7:0] wd,
    // read port
    input wire logic [12:0] ra,
    output logic [7:0] rd
);
    logic [7:0] mem [0:TXQ_DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[wa] <= wd;
        end
        rd <= mem[ra];
    end
endmodule

// File: design/spi_link.sv
// Purpose: serial shifter on the link clock
// Assumes: mode 0 framing, msb first, chip select low for a whole frame
// Notes: chip select ends the frame asynchronously since sck stops outside it
`timescale 1ns/10ps
module spi_link
    import txq_pkg::*;
(
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // core side
    spi_link_if.link lnk
);
    typedef struct packed {
        logic [7:0] shift;
        logic [7:0] held;
        logic [2:0] bits;
        logic toggle;
    } link_s;

    link_s s, next_s;
    logic [6:0] out_sh;

    always_comb begin
        next_s = s;
        next_s.shift = {s.shift[6:0], si};
        next_s.bits = s.bits + 3'h1;
        // held copy stays still for four bits so the core can sample it
        if (s.bits[1:0] == 2'b11) begin
            next_s.held = next_s.shift;
            next_s.toggle = ~s.toggle;
        end
    end

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // out_byte was prepared by the core half a byte earlier
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
            out_sh <= '0;
        end else if (s.bits == 3'h0) begin
            {so, out_sh} <= lnk.out_byte;
        end else begin
            {so, out_sh} <= {out_sh, 1'b0};
        end
    end

    assign so_oe = ~cs_n;
    assign lnk.evt_toggle = s.toggle;
    assign lnk.held = s.held;
endmodule

// File: design/tx_queue_core.sv
// Purpose: transmit queue enqueue, registers and receive frame layout
// Assumes: host reaches registers and queues over the serial link only
// Notes: register reads need about 150 ns of core time per half byte
//
// Operation
// RQ1 - flow control output follows transmit control bit 3
// RQ2 - padding output follows transmit control bit 2
// RQ3 - crc generation output follows transmit control bit 1
// RQ4 - no frame leaves the queue while transmit control bit 0 is clear; the core checks bit 0 only before starting a frame
// RQ5 - transmit control bits 8 to 5 enable the four checksum generators
// RQ6 - free transmit memory in bytes reads at 0x78, thirteen bits wide
// RQ7 - writing manual enqueue bit queues exactly the frame being prepared
// RQ8 - manual enqueue bit clears after the frame is sent; host waits for it
// RQ9 - space request raises status bit 6 once free memory suffices
// RQ10 - space request bit clears after a frame is sent; host waits for it
// RQ11 - with auto enqueue set, each completely written frame is queued
// RQ12 - queue data access opens only while receive queue bit 3 is set
// RQ13 - data pointer bit 14 advances the queue pointer per data byte
// RQ14 - enable bit 14 gates the transmit done status onto the interrupt
// RQ15 - enable bit 6 gates the space available status onto the interrupt
// RQ16 - writing one clears an interrupt status bit
// RQ17 - host programs needed queue space in double words at 0x9e
// RQ18 - receive frame starts with the header status word
// RQ19 - receive frame word two holds the header byte count
// RQ20 - receive data follow from offset 4, low byte first
// RQ21 - received crc bytes stay in the receive data area
// RQ22 - transmit frame holds control word, byte count, then data
// RQ23 - control bit 15 asks for the done interrupt; bits 5-0 name the frame
// RQ24 - host always writes a correct nonzero byte count
// RQ25 - host clears the queue access bit after its burst
// RQ26 - free space is compared every cycle while a request is pending
`timescale 1ns/10ps
module tx_queue_core
    import txq_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic srst,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    // transmit stream towards the mac
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic tx_done,
    output logic [5:0] frame_identifier,
    // mac options
    output logic tx_enable,
    output logic flow_control_en,
    output logic pad_en,
    output logic crc_en,
    output logic [3:0] checksum_en,
    // received frame at the head of the receive queue
    input wire logic [15:0] receive_header_status,
    input wire logic [11:0] receive_header_byte_count,
    input wire logic [7:0] rx_data,
    output logic rx_take,
    // host interrupt
    output logic host_irq_n
);
    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] tg_sync;
        logic [15:0] nib;
        op_e op;
        logic [7:0] cmd0;
        logic [5:0] addr;
        logic [3:0] be;
        logic [1:0] lane;
        logic lane_ok;
        logic [7:0] out_byte;
        logic [2:0] rx_idx;
        logic [15:0] txc;
        logic [15:0] txqc;
        logic [15:0] rxqc;
        logic [15:0] txdp;
        logic [15:0] interrupt_enable;
        logic [15:0] interrupt_status;
        logic [15:0] space;
        logic [10:0] cnt;
        logic [12:0] wr_base;
        logic [12:0] rd_base;
        logic [12:0] occupied;
        logic [10:0] pending;
        tx_e tst;
        logic [10:0] tx_i;
        logic [15:0] tx_cw;
        logic [10:0] tx_len;
        logic [7:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic tx_done;
        logic [5:0] fid;
        logic rx_take;
    } core_s;

    core_s s, next_s;
    spi_link_if link_bus ();
    logic mem_we;
    logic [12:0] mem_wa;
    logic [12:0] mem_ra;
    logic [7:0] mem_rd;
    logic [12:0] free;
    logic evt;
    logic commit;
    logic [2:0] ln;
    logic [10:0] ptr;
    reg_e wsel;

    spi_link u_link (
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe(so_oe),
        .lnk(link_bus.link)
    );

    txq_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .wa(mem_wa),
        .wd(link_bus.held),
        .ra(mem_ra),
        .rd(mem_rd)
    );

    // ring addition inside the transmit space
    function automatic logic [12:0] wrap(input logic [12:0] a, input logic [12:0] b);
        logic [13:0] t;
        t = {1'b0, a} + {1'b0, b};
        return (t >= {1'b0, TXQ_SIZE}) ? 13'(t - {1'b0, TXQ_SIZE}) : t[12:0];
    endfunction

    // header plus data rounded up to a double word
    function automatic logic [12:0] span(input logic [10:0] n);
        logic [12:0] t;
        t = HDR_BYTES + {2'h0, n} + 13'h0003;
        return {t[12:2], 2'b00};
    endfunction

    function automatic reg_e reg_sel(input logic [7:0] ofs);
        case (ofs)
            OFS_TXC: return R_TXC;
            OFS_TXFREE: return R_FREE;
            OFS_TXQC: return R_TXQC;
            OFS_RXQC: return R_RXQC;
            OFS_TXDP: return R_TXDP;
            OFS_IER: return R_IER;
            OFS_ISR: return R_ISR;
            OFS_SPACE: return R_SPACE;
            default: return R_NONE;
        endcase
    endfunction

    // first enabled byte lane at or above from, with a found flag on top
    function automatic logic [2:0] next_lane(input logic [3:0] be, input logic [2:0] from);
        logic [2:0] r;
        r = 3'b000;
        for (int i = 3; i >= 0; i--) begin
            if (be[i] && 3'(i) >= from) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] put(input logic [15:0] old, input logic [7:0] b,
                                        input logic hi);
        return hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction

    function automatic logic [7:0] rd_byte(input core_s st, input logic [5:0] a,
                                           input logic [1:0] l, input logic [12:0] fr);
        logic [15:0] w;
        w = '0;
        case (reg_sel({a, l[1], 1'b0}))
            R_TXC: w = st.txc;
            R_FREE: w = {3'h0, fr}; // RQ6
            R_TXQC: w = st.txqc;
            R_RXQC: w = st.rxqc;
            R_TXDP: w = st.txdp;
            R_IER: w = st.interrupt_enable;
            R_ISR: w = st.interrupt_status;
            R_SPACE: w = st.space;
            default: w = '0;
        endcase
        return l[0] ? w[15:8] : w[7:0];
    endfunction

    always_comb begin
        next_s = s;
        next_s.tx_done = 1'b0;
        next_s.rx_take = 1'b0;
        commit = 1'b0;
        mem_we = 1'b0;
        ptr = s.txdp[10:0];
        mem_wa = wrap(s.wr_base, {2'h0, ptr});
        mem_ra = wrap(s.rd_base, {2'h0, s.tx_i});
        free = TXQ_SIZE - s.occupied; // RQ6
        ln = next_lane(s.be, 3'h0);
        wsel = reg_sel({s.addr, s.lane[1], 1'b0});
        next_s.cs_sync = {s.cs_sync[1:0], cs_n};
        next_s.tg_sync = {s.tg_sync[1:0], link_bus.evt_toggle};
        // cs path as deep as the event path so the last byte is not dropped
        evt = (s.tg_sync[2] ^ s.tg_sync[1]) & ~s.cs_sync[2];
        if (s.cs_sync[2]) begin
            next_s.nib = '0;
            next_s.rx_idx = '0;
        end
        if (evt) begin
            next_s.nib = s.nib + 16'h0001;
            if (s.nib == 16'h0000) begin
                next_s.op = op_e'(link_bus.held[3:2]);
            end
            if (s.nib == 16'h0001) begin
                next_s.cmd0 = link_bus.held;
            end
            if (s.nib == 16'h0002) begin
                next_s.addr = {s.cmd0[1:0], link_bus.held[3:0]};
                next_s.be = s.cmd0[5:2];
                ln = next_lane(s.cmd0[5:2], 3'h0);
                {next_s.lane_ok, next_s.lane} = ln;
            end
            // half a byte ahead: prepare the next byte to shift out
            if (!s.nib[0]) begin
                if ((s.nib == 16'h0000 && link_bus.held[3:2] == OP_RXQ_RD) ||
                    (s.nib != 16'h0000 && s.op == OP_RXQ_RD)) begin
                    next_s.out_byte = 8'h00;
                    if (s.rxqc[RQ_DMA]) begin // RQ12
                        case (s.rx_idx)
                            3'h0: next_s.out_byte = receive_header_status[7:0]; // RQ18
                            3'h1: next_s.out_byte = receive_header_status[15:8]; // RQ18
                            3'h2: next_s.out_byte = receive_header_byte_count[7:0]; // RQ19
                            3'h3: next_s.out_byte = {4'h0, receive_header_byte_count[11:8]}; // RQ19
                            default: begin
                                // crc bytes pass through like any data byte
                                next_s.out_byte = rx_data; // RQ20 RQ21
                                next_s.rx_take = 1'b1;
                            end
                        endcase
                        if (s.rx_idx != 3'h4) begin
                            next_s.rx_idx = s.rx_idx + 3'h1;
                        end
                    end
                end else if (s.op == OP_REG_RD && s.nib >= 16'h0002) begin
                    if (s.nib != 16'h0002) begin
                        ln = next_lane(s.be, {1'b0, s.lane} + 3'h1);
                        {next_s.lane_ok, next_s.lane} = ln;
                    end
                    next_s.out_byte = ln[2] ? rd_byte(s, next_s.addr, ln[1:0], free) : 8'h00;
                end
            end
            // a whole data byte has arrived
            if (s.nib[0] && s.nib >= 16'h0005 && s.op == OP_REG_WR && s.lane_ok) begin
                case (wsel)
                    R_TXC: next_s.txc = put(s.txc, link_bus.held, s.lane[0]);
                    R_TXQC: begin
                        if (!s.lane[0]) begin
                            if (link_bus.held[TQ_MANUAL]) begin
                                next_s.txqc[TQ_MANUAL] = 1'b1;
                                commit = 1'b1; // RQ7
                            end
                            if (link_bus.held[TQ_SPACE]) begin
                                next_s.txqc[TQ_SPACE] = 1'b1; // RQ9
                            end
                            next_s.txqc[TQ_AUTO] = link_bus.held[TQ_AUTO]; // RQ11
                        end
                    end
                    R_RXQC: next_s.rxqc = put(s.rxqc, link_bus.held, s.lane[0]);
                    R_TXDP: next_s.txdp = put(s.txdp, link_bus.held, s.lane[0]);
                    R_IER: next_s.interrupt_enable = put(s.interrupt_enable, link_bus.held, s.lane[0]);
                    R_ISR: next_s.interrupt_status = s.interrupt_status & ~put(16'h0000, link_bus.held, s.lane[0]); // RQ16
                    R_SPACE: next_s.space = put(s.space, link_bus.held, s.lane[0]); // RQ17
                    default: begin
                    end
                endcase
                {next_s.lane_ok, next_s.lane} = next_lane(s.be, {1'b0, s.lane} + 3'h1);
            end
            if (s.nib[0] && s.nib >= 16'h0003 && s.op == OP_TXQ_WR && s.rxqc[RQ_DMA] &&
                {2'h0, ptr} < HDR_BYTES + {2'h0, FRAME_MAX}) begin // RQ12
                mem_we = 1'b1; // RQ22
                if (ptr == 11'h002) begin
                    next_s.cnt[7:0] = link_bus.held;
                end
                if (ptr == 11'h003) begin
                    next_s.cnt[10:8] = link_bus.held[2:0];
                end
                if (s.txdp[DP_AUTOINC]) begin
                    next_s.txdp[10:0] = ptr + 11'h001; // RQ13
                end
                if (s.txqc[TQ_AUTO] && {2'h0, ptr} >= HDR_BYTES &&
                    {2'h0, ptr} + 13'h0001 == HDR_BYTES + {2'h0, s.cnt}) begin
                    commit = 1'b1; // RQ11
                end
            end
        end
        if (commit) begin
            next_s.wr_base = wrap(s.wr_base, span(next_s.cnt));
            next_s.occupied = s.occupied + span(next_s.cnt);
            next_s.pending = s.pending + 11'h001;
            next_s.txdp[10:0] = '0;
        end
        // drain: fetch a byte, use it, repeat
        unique case (s.tst)
            TX_IDLE: begin
                if (s.txc[TXC_EN] && s.pending != 11'h000) begin // RQ4
                    next_s.tx_i = '0;
                    next_s.tst = TX_ADDR;
                end
            end
            TX_ADDR: next_s.tst = TX_LOAD;
            TX_LOAD: begin
                next_s.tst = TX_ADDR;
                next_s.tx_i = s.tx_i + 11'h001;
                case (s.tx_i)
                    11'h000: next_s.tx_cw[7:0] = mem_rd;
                    11'h001: next_s.tx_cw[15:8] = mem_rd;
                    11'h002: next_s.tx_len[7:0] = mem_rd;
                    11'h003: next_s.tx_len[10:8] = mem_rd[2:0];
                    default: begin
                        next_s.tx_i = s.tx_i;
                        next_s.tx_data = mem_rd;
                        next_s.tx_valid = 1'b1;
                        next_s.tx_last = {2'h0, s.tx_i} + 13'h0001 ==
                                         HDR_BYTES + {2'h0, s.tx_len};
                        next_s.tst = TX_SEND;
                    end
                endcase
            end
            TX_SEND: begin
                if (tx_ready) begin
                    next_s.tx_valid = 1'b0;
                    next_s.tx_last = 1'b0;
                    next_s.tx_i = s.tx_i + 11'h001;
                    next_s.tst = s.tx_last ? TX_DONE : TX_ADDR;
                end
            end
            TX_DONE: begin
                next_s.rd_base = wrap(s.rd_base, span(s.tx_len));
                next_s.occupied = next_s.occupied - span(s.tx_len);
                next_s.pending = next_s.pending - 11'h001;
                next_s.fid = s.tx_cw[5:0]; // RQ23
                next_s.tx_done = 1'b1;
                next_s.txqc[TQ_MANUAL] = 1'b0; // RQ8
                next_s.txqc[TQ_SPACE] = 1'b0; // RQ10
                if (s.tx_cw[CW_INTR]) begin
                    next_s.interrupt_status[IRQ_TXDONE] = 1'b1; // RQ23
                end
                next_s.tst = TX_IDLE;
            end
        endcase
        // status set after the host clear, so a coinciding event survives
        if (s.txqc[TQ_SPACE] && {5'h00, free[12:2]} >= s.space) begin
            next_s.interrupt_status[IRQ_SPACE] = 1'b1; // RQ9 RQ26
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link_bus.out_byte = s.out_byte;
    assign tx_data = s.tx_data;
    assign tx_valid = s.tx_valid;
    assign tx_last = s.tx_last;
    assign tx_done = s.tx_done;
    assign frame_identifier = s.fid;
    assign rx_take = s.rx_take;
    assign tx_enable = s.txc[TXC_EN]; // RQ4
    assign flow_control_en = s.txc[TXC_FLOW]; // RQ1
    assign pad_en = s.txc[TXC_PAD]; // RQ2
    assign crc_en = s.txc[TXC_CRC]; // RQ3
    assign checksum_en = s.txc[TXC_CSUM +: 4]; // RQ5
    assign host_irq_n = ~|(s.interrupt_status & s.interrupt_enable); // RQ14 RQ15
endmodule

// File: bench/tx_queue_core_asserts.sv
// Purpose: port checks of the transmit queue core
// Assumes: one core clock domain; link side judged by the bench
// Notes: bound to every instance of the core
`timescale 1ns/10ps
module txq_checker (
    // system
    input wire logic clk,
    input wire logic srst,
    // watched ports
    input wire logic cs_n,
    input wire logic so,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic tx_done,
    input wire logic [5:0] frame_identifier,
    input wire logic tx_enable,
    input wire logic rx_take,
    input wire logic host_irq_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_valid_holds:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte withdrawn before accept");
    a_start_enabled:
    assert property ($rose(tx_valid) |-> tx_enable)
        else $error("byte offered while transmit disabled");
    a_done_after_last:
    assert property (tx_valid && tx_ready && tx_last |-> ##[1:3] tx_done)
        else $error("no done after last byte");
    a_done_pulse:
    assert property (tx_done |=> !tx_done)
        else $error("done longer than one cycle");
    a_byte_gap:
    assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("bytes closer than allowed");
    a_last_valid:
    assert property (tx_last |-> tx_valid)
        else $error("last without valid");
    a_id_stable:
    assert property (!tx_done && !$past(srst) |-> $stable(frame_identifier))
        else $error("frame id moved without done");
    a_take_pulse:
    assert property (rx_take |=> !rx_take)
        else $error("take longer than one cycle");
    a_so_idle:
    assert property (cs_n |-> !so)
        else $error("serial out busy outside frame");
    a_reset_quiet:
    assert property (disable iff (1'b0) srst |=> !tx_valid && !tx_done && host_irq_n)
        else $error("outputs active after reset");
endmodule

bind tx_queue_core txq_checker chk_u (.clk(clk), .srst(srst), .cs_n(cs_n), .so(so),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_done(tx_done), .frame_identifier(frame_identifier), .tx_enable(tx_enable),
    .rx_take(rx_take), .host_irq_n(host_irq_n));

// File: bench/spi_host_model.sv
// Purpose: serial link master standing in for the host
// Assumes: mode 0, msb first, 64 ns link clock
// Notes: link clock runs only inside frames
`timescale 1ns/10ps
module spi_host_model (
    // serial pins
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    logic [7:0] tx_b [16];
    logic [7:0] rx_b [16];
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic frame(input int n);
        #13;
        cs_n = 1'b0;
        for (int b = 0; b < n; b++) begin
            for (int i = 7; i >= 0; i--) begin
                si = tx_b[b][i];
                #32 sck = 1'b1;
                rx_b[b][i] = so;
                #32 sck = 1'b0;
            end
        end
        // core takes the last byte some clocks after its final edge
        #200;
        cs_n = 1'b1;
        // released line must not keep its last level
        si = ~si;
        #250;
    endtask
endmodule

// File: bench/test_tx_queue_enqueue_and_rx_frame_layout.sv
// Purpose: self-checking bench of the transmit queue core
// Assumes: host model on the link, bench acts as mac and receive queue
// Notes: mac stalls every other cycle
`timescale 1ns/10ps
module test_tx_queue_enqueue_and_rx_frame_layout;
    import txq_pkg::*;
    typedef struct packed {logic [15:0] w; logic [7:0] e;} row_s;
    row_s rows [6] = '{'{16'h0001, 8'h01}, '{16'h0002, 8'h02}, '{16'h0004, 8'h04},
        '{16'h0008, 8'h08}, '{16'h01e0, 8'hf0}, '{16'h0000, 8'h00}};
    logic clk = 1'b0, srst = 1'b1, tx_ready = 1'b0;
    logic sck, cs_n, si, so, so_oe, tx_valid, tx_last, tx_done, rx_take, host_irq_n;
    logic tx_enable, flow_control_en, pad_en, crc_en;
    logic [3:0] checksum_en;
    logic [7:0] tx_data, rx_data = 8'hd0;
    logic [5:0] frame_identifier;
    logic [8:0] got [$];
    int n_errors = 0, n_checks = 0;
    always #25 clk = ~clk;
    always @(negedge clk) tx_ready <= ~tx_ready;
    always @(negedge clk) if (rx_take) rx_data <= rx_data + 8'h01;
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
    spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    tx_queue_core dut_u (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
        .so_oe(so_oe), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_done(tx_done), .frame_identifier(frame_identifier),
        .tx_enable(tx_enable), .flow_control_en(flow_control_en), .pad_en(pad_en),
        .crc_en(crc_en), .checksum_en(checksum_en), .receive_header_status(16'h1234),
        .receive_header_byte_count(12'habc), .rx_data(rx_data), .rx_take(rx_take),
        .host_irq_n(host_irq_n));
    task automatic final_report;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic op, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        host.tx_b[0] = {1'b0, op, a[1] ? 4'b1100 : 4'b0011, a[7:6]};
        host.tx_b[1] = {a[5:2], 4'h0};
        host.tx_b[2] = d[7:0];
        host.tx_b[3] = d[15:8];
        host.frame(4);
        q = {host.rx_b[3], host.rx_b[2]};
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        acc(1'b0, a, 16'h0000, q);
        check(q, exp);
    endtask
    // queue write of n data bytes counting up from base
    task automatic txq(input logic [15:0] cw, input logic [7:0] n, input logic [7:0] base);
        host.tx_b[0] = 8'hc0;
        host.tx_b[1] = cw[7:0];
        host.tx_b[2] = cw[15:8];
        host.tx_b[3] = n;
        host.tx_b[4] = 8'h00;
        for (int i = 0; i < 8; i++) host.tx_b[5 + i] = base + 8'(i);
        host.frame(5 + int'(n));
    endtask
    task automatic stream_chk(input logic [7:0] base, input int n, input logic [5:0] id);
        int k;
        k = 0;
        while (tx_done !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k == 3000) begin
            n_errors++;
            final_report;
        end
        check(16'(got.size()), 16'(n));
        for (int i = 0; i < n; i++) check({7'h0, got[i]}, {7'h0, i == n - 1, base + 8'(i)});
        check({10'h0, frame_identifier}, {10'h0, id});
        got.delete();
    endtask
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        wr(8'h78, 16'h0000);
        rd_chk(8'h78, 16'h1800);
        rd_chk(8'ha0, 16'h0000);
        for (int r = 0; r < 6; r++) begin
            wr(8'h70, rows[r].w);
            check({8'h0, checksum_en, flow_control_en, pad_en, crc_en, tx_enable}, 16'(rows[r].e));
            rd_chk(8'h70, rows[r].w);
        end
        wr(8'h82, 16'h0008);
        wr(8'h84, 16'h4000);
        txq(16'h8005, 8'h04, 8'h11);
        wr(8'h80, 16'h0001);
        rd_chk(8'h78, 16'h17f8);
        rd_chk(8'h80, 16'h0001);
        check(16'(got.size()), 16'h0000);
        wr(8'h9e, 16'h05ff);
        wr(8'h80, 16'h0002);
        rd_chk(8'h92, 16'h0000);
        wr(8'h9e, 16'h05fe);
        rd_chk(8'h92, 16'h0040);
        check({14'h0, so_oe, host_irq_n}, 16'h0001);
        wr(8'h90, 16'h4040);
        check({15'h0, host_irq_n}, 16'h0000);
        wr(8'h70, 16'h0001);
        stream_chk(8'h11, 4, 6'h05);
        rd_chk(8'h80, 16'h0000);
        rd_chk(8'h92, 16'h4040);
        rd_chk(8'h78, 16'h1800);
        wr(8'h90, 16'h0040);
        wr(8'h92, 16'h0040);
        rd_chk(8'h92, 16'h4000);
        check({15'h0, host_irq_n}, 16'h0001);
        wr(8'h92, 16'hffff);
        rd_chk(8'h92, 16'h0000);
        wr(8'h80, 16'h0004);
        txq(16'h002a, 8'h02, 8'ha5);
        stream_chk(8'ha5, 2, 6'h2a);
        rd_chk(8'h92, 16'h0000);
        host.tx_b[0] = 8'h80;
        host.frame(7);
        check({host.rx_b[2], host.rx_b[1]}, 16'h1234);
        check({host.rx_b[4], host.rx_b[3]}, 16'h0abc);
        check({host.rx_b[6], host.rx_b[5]}, 16'hd1d0);
        wr(8'h82, 16'h0000);
        host.tx_b[0] = 8'h80;
        host.frame(3);
        check({host.rx_b[2], host.rx_b[1]}, 16'h0000);
        final_report;
    end
endmodule
